// *** hdl/sync_serial_irq_defs.vh ***
// constants for the serial port interrupt and receive timeout logic
`ifndef SYNC_SERIAL_IRQ_DEFS_VH
`define SYNC_SERIAL_IRQ_DEFS_VH
`define ADDR_W            8
`define OFF_STATUS_CLEAR  8'h14
`define OFF_RX_TIMEOUT    8'h18
`define RX_TIMEOUT_RESET  16'h0000
`define BIT_OVERRUN       2
`define BIT_TX_SERVICE    1
`define BIT_RX_SERVICE    0
`define BIT_RX_TIMEOUT    3
`define RX_SERVICE_LEVEL  4
`define TX_SERVICE_LEVEL  4
`endif

// *** hdl/sync_serial_irq_timeout.v ***
// interrupt generation and receive timeout for the synchronous serial port
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "sync_serial_irq_defs.vh"
module sync_serial_irq_timeout #(
  parameter LEVEL_W = 5
) (
  // clock and reset
  input  wire               clk_i,
  input  wire               reset_n_i,
  // register port
  input  wire [7:0]         addr_i,
  input  wire [31:0]        wdata_i,
  input  wire               wr_i,
  input  wire               rd_i,
  output reg  [31:0]        rdata_o,
  // state from the rest of the port
  input  wire [LEVEL_W-1:0] rx_level_i,
  input  wire [LEVEL_W-1:0] tx_level_i,
  input  wire               rx_full_i,
  input  wire               rx_frame_i,
  input  wire               port_enable_i,
  input  wire               rx_irq_enable_i,
  input  wire               tx_irq_enable_i,
  input  wire               overrun_irq_enable_i,
  // interrupts
  output reg                rx_service_irq_o,
  output reg                tx_service_irq_o,
  output reg                rx_overrun_irq_o,
  output reg                rx_timeout_irq_o,
  output reg                combined_port_irq_o
);

  reg  [15:0] rx_timeout_count_reg;
  reg  [15:0] wait_cnt_reg;
  reg  [15:0] wait_cnt_next;
  reg         waiting_reg;
  reg         waiting_next;
  reg         rx_raw_reg;
  reg         tx_raw_reg;
  reg         overrun_raw_reg;
  reg         overrun_raw_next;
  reg         timeout_reg;
  reg         timeout_next;
  reg  [31:0] rdata_next;

  wire wr_timeout = wr_i & (addr_i == `OFF_RX_TIMEOUT);
  wire wr_clear   = wr_i & (addr_i == `OFF_STATUS_CLEAR);
  wire rx_raw     = (rx_level_i >= `RX_SERVICE_LEVEL);
  // a disabled port keeps the transmit request raised so software can pre-fill
  wire tx_raw     = ~port_enable_i | (tx_level_i <= `TX_SERVICE_LEVEL);
  wire rx_en      = rx_raw & rx_irq_enable_i;
  wire tx_en      = tx_raw & tx_irq_enable_i;
  wire ovr_en     = overrun_raw_reg & overrun_irq_enable_i;
  wire rx_fell    = rx_raw_reg & ~rx_raw;

  always @* begin
    // overrun: set wins over any clear in the same cycle
    overrun_raw_next = overrun_raw_reg;
    if (wr_clear | wr_timeout | ~overrun_irq_enable_i) begin
      overrun_raw_next = 1'b0;
    end
    if (rx_frame_i & rx_full_i & overrun_irq_enable_i) begin
      overrun_raw_next = 1'b1;
    end
  end

  always @* begin
    waiting_next  = waiting_reg;
    wait_cnt_next = wait_cnt_reg;
    timeout_next  = timeout_reg;
    if (wr_timeout) begin
      timeout_next = 1'b0;
    end
    if (rx_raw) begin
      waiting_next = 1'b0;
    end else if (rx_fell) begin
      waiting_next  = 1'b1;
      wait_cnt_next = 16'h0001;
    end else if (waiting_reg) begin
      if (rx_timeout_count_reg == `RX_TIMEOUT_RESET) begin
        waiting_next = 1'b0;
      end else if (wait_cnt_reg >= rx_timeout_count_reg) begin
        waiting_next = 1'b0;
        timeout_next = 1'b1;
      end else begin
        wait_cnt_next = wait_cnt_reg + 16'h0001;
      end
    end
  end

  always @* begin
    rdata_next = 32'h0000_0000;
    case (addr_i)
      `OFF_STATUS_CLEAR: begin
        rdata_next[`BIT_RX_SERVICE] = rx_raw_reg;
        // both service bits show the unmasked request with the same one-cycle lag
        rdata_next[`BIT_TX_SERVICE] = tx_raw_reg;
        rdata_next[`BIT_OVERRUN]    = overrun_raw_reg;
        rdata_next[`BIT_RX_TIMEOUT] = timeout_reg;
      end
      `OFF_RX_TIMEOUT: begin
        rdata_next[15:0] = rx_timeout_count_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_timeout_count_reg <= `RX_TIMEOUT_RESET;
      wait_cnt_reg         <= 16'h0000;
      waiting_reg          <= 1'b0;
      rx_raw_reg           <= 1'b0;
      tx_raw_reg           <= 1'b0;
      overrun_raw_reg      <= 1'b0;
      timeout_reg          <= 1'b0;
      rdata_o              <= 32'h0000_0000;
      rx_service_irq_o     <= 1'b0;
      tx_service_irq_o     <= 1'b0;
      rx_overrun_irq_o     <= 1'b0;
      rx_timeout_irq_o     <= 1'b0;
      combined_port_irq_o  <= 1'b0;
    end else begin
      if (wr_timeout) begin
        rx_timeout_count_reg <= wdata_i[15:0];
      end
      wait_cnt_reg        <= wait_cnt_next;
      waiting_reg         <= waiting_next;
      rx_raw_reg          <= rx_raw;
      tx_raw_reg          <= tx_raw;
      overrun_raw_reg     <= overrun_raw_next;
      timeout_reg         <= timeout_next;
      rdata_o             <= rd_i ? rdata_next : 32'h0000_0000;
      rx_service_irq_o    <= rx_en;
      tx_service_irq_o    <= tx_en;
      rx_overrun_irq_o    <= overrun_raw_next & overrun_irq_enable_i;
      rx_timeout_irq_o    <= timeout_next;
      combined_port_irq_o <= rx_en | tx_en | (overrun_raw_next & overrun_irq_enable_i) | timeout_next;
    end
  end

endmodule // sync_serial_irq_timeout

// *** dv/irq_ctrl_model.sv ***
// stand-in for the system interrupt controller
`timescale 1ns/1ps
module irq_ctrl_model(input wire clk_i,rx_service_irq_o,tx_service_irq_o,rx_overrun_irq_o,rx_timeout_irq_o,to_en_i,
  output logic pend_o);
  // the timeout source is masked only here, never in the port
  always @(posedge clk_i) pend_o <= rx_service_irq_o|tx_service_irq_o|rx_overrun_irq_o|rx_timeout_irq_o&to_en_i;
endmodule // irq_ctrl_model

// *** dv/irq_checker_assertions.sv ***
// port assertions for the serial port interrupt block
`timescale 1ns/1ps
module irq_checker #(parameter LEVEL_W=5)(input wire clk_i,reset_n_i,wr_i,rd_i,rx_full_i,rx_frame_i,
  port_enable_i,rx_irq_enable_i,tx_irq_enable_i,overrun_irq_enable_i,rx_service_irq_o,tx_service_irq_o,
  rx_overrun_irq_o,rx_timeout_irq_o,combined_port_irq_o,input wire [7:0] addr_i,input wire [31:0] rdata_o,
  input wire [LEVEL_W-1:0] rx_level_i,tx_level_i);
  logic up;
  wire w18=wr_i&&addr_i==8'h18;
  // skip the first edge after reset, where the past still sees reset values
  always @(posedge clk_i) up<=reset_n_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_comb_or: assert property(combined_port_irq_o==(rx_service_irq_o|tx_service_irq_o|rx_overrun_irq_o|
    rx_timeout_irq_o)) else $error("combined");
  a_rx_level: assert property(up|->rx_service_irq_o==$past(rx_level_i>=4&&rx_irq_enable_i)) else $error("rx");
  a_tx_level: assert property(up|->tx_service_irq_o==$past((tx_level_i<=4||!port_enable_i)&&tx_irq_enable_i))
    else $error("tx");
  a_rdata_idle: assert property(up&&!$past(rd_i)|->rdata_o==0) else $error("rdata");
  a_tmo_sticky: assert property(rx_timeout_irq_o&&!w18|=>rx_timeout_irq_o) else $error("tmo drop");
  a_tmo_clear: assert property(rx_timeout_irq_o&&w18|=>!rx_timeout_irq_o) else $error("tmo clear");
  a_ovr_set: assert property(rx_frame_i&&rx_full_i&&overrun_irq_enable_i|=>rx_overrun_irq_o) else $error("ovr");
  a_ovr_clear: assert property((w18||wr_i&&addr_i==8'h14)&&!rx_frame_i|=>!rx_overrun_irq_o) else $error("ovr clr");
  a_ovr_mask: assert property(!overrun_irq_enable_i|=>!rx_overrun_irq_o) else $error("ovr mask");
  c_tmo: cover property(rx_timeout_irq_o);
  c_ovr: cover property(rx_overrun_irq_o);
  c_tx: cover property(tx_service_irq_o);
endmodule // irq_checker
bind sync_serial_irq_timeout irq_checker #(.LEVEL_W(LEVEL_W)) chk_u(.*);

// *** dv/tb_top.sv ***
// self-checking bench for the serial port interrupt block
`timescale 1ns/1ps
module tb_top;
  logic clk_i=0,reset_n_i=0,wr_i=0,rd_i=0,rx_full_i=0,rx_frame_i=0,port_enable_i=1,to_en_i=1;
  logic rx_irq_enable_i=1,tx_irq_enable_i=1,overrun_irq_enable_i=1;
  logic [7:0] addr_i=0;
  logic [31:0] wdata_i=0;
  logic [4:0] rx_level_i=0,tx_level_i=0;
  wire [31:0] rdata_o;
  wire rx_service_irq_o,tx_service_irq_o,rx_overrun_irq_o,rx_timeout_irq_o,combined_port_irq_o,pend_o;
  int err_count=0,tests_run=0;
  always #25 clk_i=~clk_i;
  sync_serial_irq_timeout dut_u(.*);
  irq_ctrl_model vic_u(.*);
  task cyc(int n); repeat(n) @(posedge clk_i); endtask
  task chk(logic [31:0] g,e);
    tests_run++;
    if(g!==e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h",$time,g,e);
    end
  endtask
  task wr(logic [7:0] a,logic [31:0] d); @(posedge clk_i); addr_i<=a; wdata_i<=d; wr_i<=1; cyc(1); wr_i<=0; endtask
  task rd(logic [7:0] a,logic [31:0] e); @(posedge clk_i); addr_i<=a; rd_i<=1; cyc(1); rd_i<=0; cyc(1); chk(rdata_o,e); endtask
  task pulse; rx_full_i<=1; rx_frame_i<=1; cyc(1); rx_frame_i<=0; cyc(1); endtask
  task t_levels;
    rx_level_i<=3; tx_level_i<=5; cyc(2); chk({combined_port_irq_o,tx_service_irq_o,rx_service_irq_o},0);
    rx_level_i<=4; tx_level_i<=4; cyc(2); chk(combined_port_irq_o,1); rd(8'h14,4'h3); rd(8'h20,0);
    port_enable_i<=0; tx_level_i<=5; rx_irq_enable_i<=0; cyc(2); chk({tx_service_irq_o,rx_service_irq_o},2'h2);
    tx_irq_enable_i<=0; cyc(2); chk(combined_port_irq_o,0);
    port_enable_i<=1; rx_irq_enable_i<=1; tx_irq_enable_i<=1; $display("levels done");
  endtask
  task t_timeout;
    wr(8'h18,32'h0000_0006); rd(8'h18,4'h6);
    rx_level_i<=3; cyc(3); rx_level_i<=4; cyc(8); chk(rx_timeout_irq_o,0);
    rx_level_i<=3; cyc(7); chk(rx_timeout_irq_o,0); cyc(1); chk(rx_timeout_irq_o,1);
    chk(combined_port_irq_o,1); to_en_i<=0; cyc(2); chk(pend_o,0);
    to_en_i<=1; cyc(2); chk(pend_o,1);
    rd(8'h14,4'h8); wr(8'h18,0); cyc(1); chk(rx_timeout_irq_o,0);
    rx_level_i<=4; cyc(2); rx_level_i<=3; cyc(12); chk(rx_timeout_irq_o,0); $display("timeout done");
  endtask
  task t_overrun;
    pulse; chk(rx_overrun_irq_o,1); wr(8'h14,0); cyc(1); chk(rx_overrun_irq_o,0);
    pulse; wr(8'h18,0); cyc(1); chk(rx_overrun_irq_o,0);
    pulse; overrun_irq_enable_i<=0; cyc(2); chk(rx_overrun_irq_o,0); $display("overrun done");
  endtask
  task summarize;
    $display("tests_run=%0d err_count=%0d",tests_run,err_count);
    if(err_count==0&&tests_run>0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(5);
    reset_n_i<=1;
    t_levels;
    t_timeout;
    t_overrun;
    summarize;
  end
  // about 80 cycles of traffic expected
  initial begin
    #20000;
    err_count++;
    summarize;
  end
endmodule // tb_top
